//--- tmg_pkg.sv
// Purpose: shared constants and types for the touch interrupt and multi-touch gate
// Assumes: eight sense inputs, 8-bit registers on a plain address port
// Notes: offsets are byte addresses of the register port
package tmg_pkg;
    localparam int NUM_INPUTS = 8;
    localparam int DELTA_W = 8;

    // register offsets
    localparam logic [7:0] ADDR_IRQ_EN = 8'h27;
    localparam logic [7:0] ADDR_RPT_EN = 8'h28;
    localparam logic [7:0] ADDR_MT_CFG = 8'h2A;
    localparam logic [7:0] ADDR_PTRN_CFG = 8'h2B;
    localparam logic [7:0] ADDR_PTRN = 8'h2D;
    localparam logic [7:0] ADDR_STATUS = 8'h40;
    localparam logic [7:0] ADDR_TOUCH = 8'h41;

    // reset values
    localparam logic [7:0] RST_IRQ_EN = 8'hFF;
    localparam logic [7:0] RST_RPT_EN = 8'hFF;
    localparam logic [7:0] RST_MT_CFG = 8'h80;
    localparam logic [7:0] RST_PTRN_CFG = 8'h00;
    localparam logic [7:0] RST_PTRN = 8'hFF;

    // field positions
    localparam int MT_BLK_BIT = 7;
    localparam int MT_LIM_LSB = 2;
    localparam int PC_EN_BIT = 7;
    localparam int PC_TH_LSB = 2;
    localparam int PC_CMP_BIT = 1;
    localparam int PC_ALERT_BIT = 0;
    localparam int ST_IRQ_BIT = 0;
    localparam int ST_SIMULTANEOUS_TOUCH_FLAG_BIT = 1;
    localparam int ST_PTRN_BIT = 2;

    // pattern threshold scale codes
    localparam logic [1:0] PTH_12P5 = 2'h0;
    localparam logic [1:0] PTH_25 = 2'h1;
    localparam logic [1:0] PTH_37P5 = 2'h2;

    typedef struct packed {
        logic [NUM_INPUTS-1:0] touch;
        logic [NUM_INPUTS-1:0] release_ev;
        logic [NUM_INPUTS-1:0] held;
        logic [NUM_INPUTS-1:0] repeat_tick;
        logic [NUM_INPUTS-1:0] noise;
    } tmg_front_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmg_bus_s;

    typedef enum logic [1:0] {TMG_IDLE, TMG_NORMAL, TMG_PTRN_BLOCK} tmg_state_e;
endpackage : tmg_pkg

//--- tmg_ptrn_check.sv
// Purpose: pattern threshold and per-input exceed test
// Assumes: thresholds are 8-bit counts, deltas unsigned
// Notes: purely combinational, one instance per gate
`timescale 1ns/1ps
module tmg_ptrn_check import tmg_pkg::*; #(
    parameter int N = NUM_INPUTS,
    parameter int W = DELTA_W
) (
    input wire logic [N*W-1:0] delta,
    input wire logic [N*W-1:0] touch_thresh,
    input wire logic [W-1:0] standby_thresh,
    input wire logic standby,
    input wire logic [1:0] scale,
    output logic [N-1:0] over
);
    // scale a threshold; 37.5 percent is a quarter plus an eighth
    function automatic logic [W-1:0] scale_th(input logic [W-1:0] th, input logic [1:0] s);
        case (s)
            PTH_12P5: scale_th = th >> 3;
            PTH_25: scale_th = th >> 2;
            PTH_37P5: scale_th = (th >> 2) + (th >> 3);
            default: scale_th = th;
        endcase
    endfunction : scale_th

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_in
            logic [W-1:0] base;
            // standby uses its own common threshold
            assign base = standby ? standby_thresh : touch_thresh[i*W +: W];
            assign over[i] = delta[i*W +: W] > scale_th(base, scale);
        end
    endgenerate
endmodule : tmg_ptrn_check

//--- tmg_gate.sv
// Purpose: qualifies touch events into status, interrupt and alert
// Assumes: front-end strobes are one-cycle pulses once per polling cycle
// Notes: irq_n and alert_n are active-low levels from flip-flops
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RL1) set touch irq enable bit lets a touch on that input assert irq
// (RL2) cleared enable keeps irq quiet but status still shows the touch
// (RL3) repeat off: irq on touch and on release if release irq selected
// (RL4) repeat on, short touch: irq on touch and gated release
// (RL5) repeat on, held: irq on touch and every repeat tick while held
// (RL6) repeat enable register, bit per input, resets all ones
// (RL7) blocking disabled: no touch is ever blocked; the code still clears all touches while a pattern condition holds
// (RL8) blocking enabled: flag at most limit touches, keep them until release
// (RL9) after a release, refill accepted set from input 1 upward
// (RL10) limit field 00..11 means 1..4 touches, resets to one
// (RL11) too many touches with blocking sets the simultaneous touch flag
// (RL12) pattern detection only when its enable is set, reset disabled
// (RL13) pattern threshold scale: 12.5, 25, 37.5, 100 percent
// (RL14) pattern threshold from touch threshold, or standby threshold in standby
// (RL15) count mode: event when enough inputs over threshold or noisy
// (RL16) compare mode: event when every selected input over or noisy
// (RL17) pattern event blocks all touches and sets pattern flag
// (RL18) all blocked while condition holds, released when it ends
// (RL19) pattern flag stays until host clears irq flag after condition ends
// (RL20) alert enable decides whether a pattern event asserts alert
// (RL21) pattern register bit per input, resets all ones
// (RL22) front-end results are evaluated once per polling cycle strobe
module tmg_gate import tmg_pkg::*; #(
    parameter int N = NUM_INPUTS,
    parameter int W = DELTA_W
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic poll_strobe,
    input wire tmg_front_s front,
    input wire logic [N*W-1:0] delta,
    input wire logic [N*W-1:0] touch_thresh,
    input wire logic [W-1:0] standby_thresh,
    input wire logic standby,
    input wire logic release_irq_select,
    input wire tmg_bus_s bus,
    output logic [7:0] rdata,
    output logic [N-1:0] touch_status,
    output logic irq_n,
    output logic alert_n
);
    logic [7:0] irq_en_q, rpt_en_q, mt_cfg_q, pc_cfg_q, ptrn_q;
    logic [N-1:0] accepted_q, accepted_d, touched_q, touched_d, over;
    logic simultaneous_touch_flag_q, ptrn_flag_q, irq_flag_q, alert_q;
    logic ptrn_cond, ptrn_cond_q, irq_event, simultaneous_touch_flag_event, clear_irq;
    logic [3:0] ptrn_need, ptrn_have;
    tmg_state_e state_q;

    // count set bits, used for pattern need and have
    function automatic logic [3:0] popcount(input logic [N-1:0] v);
        popcount = 4'h0;
        for (int k = 0; k < N; k++) popcount = popcount + {3'h0, v[k]};
    endfunction : popcount

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_en_q <= RST_IRQ_EN; // see RL1
            rpt_en_q <= RST_RPT_EN; // see RL6
            mt_cfg_q <= RST_MT_CFG; // see RL10
            pc_cfg_q <= RST_PTRN_CFG; // see RL12
            ptrn_q <= RST_PTRN; // see RL21
        end else if (clk_en && bus.wr) begin
            case (bus.addr)
                ADDR_IRQ_EN: irq_en_q <= bus.wdata;
                ADDR_RPT_EN: rpt_en_q <= bus.wdata;
                ADDR_MT_CFG: mt_cfg_q <= bus.wdata & RST_MT_CFG | bus.wdata & 8'h0C;
                ADDR_PTRN_CFG: pc_cfg_q <= bus.wdata & 8'h8F;
                ADDR_PTRN: ptrn_q <= bus.wdata;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            if (bus.rd) begin
                case (bus.addr)
                    ADDR_IRQ_EN: rdata <= irq_en_q;
                    ADDR_RPT_EN: rdata <= rpt_en_q;
                    ADDR_MT_CFG: rdata <= mt_cfg_q;
                    ADDR_PTRN_CFG: rdata <= pc_cfg_q;
                    ADDR_PTRN: rdata <= ptrn_q;
                    ADDR_STATUS: rdata <= {5'h00, ptrn_flag_q, simultaneous_touch_flag_q, irq_flag_q};
                    ADDR_TOUCH: rdata <= touched_q;
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pattern condition
    tmg_ptrn_check #(.N(N), .W(W)) u_check (
        .delta(delta),
        .touch_thresh(touch_thresh),
        .standby_thresh(standby_thresh),
        .standby(standby), // see RL14
        .scale(pc_cfg_q[PC_TH_LSB +: 2]), // see RL13
        .over(over)
    );

    assign ptrn_need = popcount(ptrn_q);
    assign ptrn_have = popcount(over | front.noise);
    // compare mode needs every selected input; count mode needs enough inputs
    always_comb begin
        if (!pc_cfg_q[PC_EN_BIT]) ptrn_cond = 1'b0; // see RL12
        else if (pc_cfg_q[PC_CMP_BIT]) ptrn_cond = ((over | front.noise) & ptrn_q) == ptrn_q; // see RL16
        else ptrn_cond = ptrn_have >= ptrn_need; // see RL15
    end

    // block state follows the condition, sampled per polling cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= TMG_IDLE;
            ptrn_cond_q <= 1'b0;
        end else if (clk_en && poll_strobe) begin // see RL22
            ptrn_cond_q <= ptrn_cond;
            case (state_q)
                TMG_IDLE: state_q <= ptrn_cond ? TMG_PTRN_BLOCK : TMG_NORMAL;
                TMG_NORMAL: if (ptrn_cond) state_q <= TMG_PTRN_BLOCK; // see RL17
                TMG_PTRN_BLOCK: if (!ptrn_cond) state_q <= TMG_NORMAL; // see RL18
                default: state_q <= TMG_NORMAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // simultaneous-touch acceptance: keep held accepted, refill from input 1
    always_comb begin
        int lim;
        int cnt;
        lim = 0;
        cnt = 0;
        touched_d = front.held | front.touch;
        accepted_d = accepted_q & touched_d; // see RL8
        simultaneous_touch_flag_event = 1'b0;
        lim = int'(mt_cfg_q[MT_LIM_LSB +: 2]) + 1; // see RL10
        if (!mt_cfg_q[MT_BLK_BIT]) begin
            accepted_d = touched_d; // see RL7
        end else begin
            cnt = int'(popcount(accepted_d));
            for (int k = 0; k < N; k++) begin
                if (touched_d[k] && !accepted_d[k]) begin
                    if (cnt < lim) begin
                        accepted_d[k] = 1'b1; // see RL9
                        cnt = cnt + 1;
                    end else begin
                        simultaneous_touch_flag_event = 1'b1; // see RL11
                    end
                end
            end
        end
        // live condition, so touches come back in the first poll after it ends
        if (ptrn_cond) accepted_d = '0; // see RL17 see RL18
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            accepted_q <= '0;
            touched_q <= '0;
        end else if (clk_en && poll_strobe) begin
            accepted_q <= accepted_d;
            touched_q <= touched_d;
        end
    end
    assign touch_status = accepted_q;

    ////////////////////////////////////////////////////////////////////////////
    // per-input interrupt causes, gated only by enable; status is not
    logic [N-1:0] cause;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cause
            logic new_t, rel, rpt;
            assign new_t = accepted_d[g] && !accepted_q[g]; // see RL3
            assign rel = accepted_q[g] && front.release_ev[g] && release_irq_select; // see RL4
            assign rpt = rpt_en_q[g] && accepted_d[g] && front.held[g] && front.repeat_tick[g]; // see RL5
            assign cause[g] = irq_en_q[g] && (new_t || rel || rpt); // see RL1 see RL2
        end
    endgenerate

    assign irq_event = poll_strobe && |cause;
    assign clear_irq = bus.wr && bus.addr == ADDR_STATUS && !bus.wdata[ST_IRQ_BIT];

    // sticky flags; a new event wins over a host clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_flag_q <= 1'b0;
            simultaneous_touch_flag_q <= 1'b0;
            ptrn_flag_q <= 1'b0;
            alert_q <= 1'b0;
        end else if (clk_en) begin
            if (clear_irq) begin
                irq_flag_q <= 1'b0;
                simultaneous_touch_flag_q <= 1'b0;
                alert_q <= 1'b0;
                if (!ptrn_cond_q) ptrn_flag_q <= 1'b0; // see RL19
            end
            if (irq_event) irq_flag_q <= 1'b1;
            if (poll_strobe && simultaneous_touch_flag_event) simultaneous_touch_flag_q <= 1'b1; // see RL11
            if (poll_strobe && ptrn_cond) begin
                ptrn_flag_q <= 1'b1; // see RL17
                if (pc_cfg_q[PC_ALERT_BIT]) alert_q <= 1'b1; // see RL20
            end
        end
    end

    assign irq_n = !irq_flag_q;
    assign alert_n = !alert_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_irq_disabled;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && (irq_en_q & (accepted_d | accepted_q)) == '0 && !irq_flag_q && !clear_irq)
            |=> irq_n;
    endproperty
    a_irq_disabled: assert property (p_irq_disabled) else $error("irq with all enables off"); // see RL2

    property p_irq_on_touch;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && irq_event) |=> !irq_n;
    endproperty
    a_irq_on_touch: assert property (p_irq_on_touch) else $error("irq event lost"); // see RL1

    property p_no_block;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && !mt_cfg_q[MT_BLK_BIT] && !ptrn_cond && state_q != TMG_PTRN_BLOCK)
            |=> touch_status == $past(front.held | front.touch);
    endproperty
    a_no_block: assert property (p_no_block) else $error("touch blocked with blocking off"); // see RL7

    property p_limit;
        @(posedge mclk) disable iff (!reset_n)
        mt_cfg_q[MT_BLK_BIT] |-> popcount(accepted_q) <= 4'(mt_cfg_q[MT_LIM_LSB +: 2]) + 4'h1;
    endproperty
    a_limit: assert property (p_limit) else $error("accepted above limit"); // see RL8

    property p_simultaneous_touch_flag;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && simultaneous_touch_flag_event) |=> simultaneous_touch_flag_q;
    endproperty
    a_simultaneous_touch_flag: assert property (p_simultaneous_touch_flag) else $error("multi flag not set"); // see RL11

    property p_ptrn_off;
        @(posedge mclk) disable iff (!reset_n)
        !pc_cfg_q[PC_EN_BIT] |-> !ptrn_cond;
    endproperty
    a_ptrn_off: assert property (p_ptrn_off) else $error("pattern active while disabled"); // see RL12

    property p_ptrn_block;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && ptrn_cond) |=> (touch_status == '0 && ptrn_flag_q);
    endproperty
    a_ptrn_block: assert property (p_ptrn_block) else $error("pattern did not block"); // see RL17

    property p_ptrn_hold;
        @(posedge mclk) disable iff (!reset_n)
        (ptrn_flag_q && ptrn_cond_q) |=> ptrn_flag_q;
    endproperty
    a_ptrn_hold: assert property (p_ptrn_hold) else $error("pattern flag cleared early"); // see RL19

    property p_alert;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && ptrn_cond && !pc_cfg_q[PC_ALERT_BIT] && alert_n) |=> alert_n;
    endproperty
    a_alert: assert property (p_alert) else $error("alert with alert disabled"); // see RL20

    property p_rel_irq;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && release_irq_select && (accepted_q & front.release_ev & irq_en_q) != '0)
            |=> !irq_n;
    endproperty
    a_rel_irq: assert property (p_rel_irq) else $error("release irq lost"); // see RL4

    // a tick on a repeat-disabled input alone must stay quiet
    property p_rpt_gated;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && !irq_flag_q && !clear_irq && accepted_d == accepted_q
            && front.repeat_tick != '0 && (front.repeat_tick & rpt_en_q) == '0
            && !(release_irq_select && (front.release_ev & accepted_q) != '0)) |=> irq_n;
    endproperty
    a_rpt_gated: assert property (p_rpt_gated) else $error("irq from repeat tick with repeat off"); // see RL3

    property p_rpt_tick;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && (rpt_en_q & irq_en_q & accepted_d & front.held & front.repeat_tick) != '0) |=> !irq_n;
    endproperty
    a_rpt_tick: assert property (p_rpt_tick) else $error("repeat tick irq lost"); // see RL5

    property p_refill;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && mt_cfg_q[MT_BLK_BIT] && mt_cfg_q[MT_LIM_LSB +: 2] == 2'h0 && accepted_q == '0
            && !ptrn_cond) |=> touch_status == ($past(touched_d) & (~$past(touched_d) + 1'b1));
    endproperty
    a_refill: assert property (p_refill) else $error("refill not from input 1 upward"); // see RL9

    property p_no_simultaneous_touch_flag;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && !mt_cfg_q[MT_BLK_BIT]) |-> !simultaneous_touch_flag_event;
    endproperty
    a_no_simultaneous_touch_flag: assert property (p_no_simultaneous_touch_flag) else $error("multi event with blocking off"); // see RL7

    property p_ptrn_cmp;
        @(posedge mclk) disable iff (!reset_n)
        (pc_cfg_q[PC_EN_BIT] && pc_cfg_q[PC_CMP_BIT] && ((over | front.noise) & ptrn_q) != ptrn_q)
            |-> !ptrn_cond;
    endproperty
    a_ptrn_cmp: assert property (p_ptrn_cmp) else $error("pattern match without every input"); // see RL16

    property p_ptrn_cnt;
        @(posedge mclk) disable iff (!reset_n)
        (pc_cfg_q[PC_EN_BIT] && !pc_cfg_q[PC_CMP_BIT] && $countones(over | front.noise) < $countones(ptrn_q))
            |-> !ptrn_cond;
    endproperty
    a_ptrn_cnt: assert property (p_ptrn_cnt) else $error("pattern count below need"); // see RL15

    property p_ptrn_release;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && !ptrn_cond && state_q == TMG_PTRN_BLOCK && (front.touch | front.held) != '0)
            |=> touch_status != '0;
    endproperty
    a_ptrn_release: assert property (p_ptrn_release) else $error("touches still blocked"); // see RL18

    property p_alert_on;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && poll_strobe && ptrn_cond && pc_cfg_q[PC_ALERT_BIT]) |=> !alert_n;
    endproperty
    a_alert_on: assert property (p_alert_on) else $error("alert missing"); // see RL20

    property p_ptrn_clear;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && clear_irq && !ptrn_cond_q && !(poll_strobe && ptrn_cond)) |=> !ptrn_flag_q;
    endproperty
    a_ptrn_clear: assert property (p_ptrn_clear) else $error("pattern flag not cleared"); // see RL19

    property p_irq_clear;
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && clear_irq && !irq_event) |=> irq_n;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared"); // see RL19
endmodule : tmg_gate

//--- tmg_host_model.sv
// Purpose: host side of the touch gate, driving the register port
// Assumes: one-cycle strobes, read data only in the cycle after the read strobe
// Notes: a released bus shows inverted address and data, never the old values
`timescale 1ns/1ps
module tmg_host_model import tmg_pkg::*; (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    output tmg_bus_s bus
);
    initial bus = '0;
    ////////////////////////////////////////////////////////////////////////////
    // one write cycle; a write of zero to status clears the flags
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr
    // read data is taken in the one cycle it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        #1 d = rdata;
    endtask : rd
endmodule : tmg_host_model

//--- touch_irq_and_multitouch_gate_tb.sv
// Purpose: self-checking bench for the touch gate
// Assumes: front end modelled by poll calls, host by the host model
// Notes: touch thresholds fixed at 40h and standby threshold at 80h so pattern thresholds are exact
`timescale 1ns/1ps
module touch_irq_and_multitouch_gate_tb import tmg_pkg::*;;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic poll_strobe = 1'b0;
    tmg_front_s front = '0;
    logic [63:0] delta = '0;
    logic [63:0] touch_thresh = {8{8'h40}};
    logic release_irq_select = 1'b0;
    logic clk_en = 1'b1;
    logic standby = 1'b0;
    logic [7:0] standby_thresh = 8'h80;
    tmg_bus_s bus;
    logic [7:0] rdata, touch_status, rd_q;
    logic irq_n, alert_n;
    int errors = 0;
    int checks_done = 0;
    logic [7:0] ra [6] = '{ADDR_IRQ_EN, ADDR_RPT_EN, ADDR_MT_CFG, ADDR_PTRN_CFG, ADDR_PTRN, 8'h00};
    logic [7:0] rv [6] = '{RST_IRQ_EN, RST_RPT_EN, RST_MT_CFG, RST_PTRN_CFG, RST_PTRN, 8'h00};

    always #5 mclk = ~mclk;
    tmg_gate dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .poll_strobe(poll_strobe), .front(front),
        .delta(delta), .touch_thresh(touch_thresh), .standby_thresh(standby_thresh), .standby(standby),
        .release_irq_select(release_irq_select), .bus(bus), .rdata(rdata), .touch_status(touch_status),
        .irq_n(irq_n), .alert_n(alert_n));
    tmg_host_model host (.mclk(mclk), .rdata(rdata), .bus(bus));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        host.rd(a, rd_q);
        check("reg", rd_q & m, e);
    endtask : rreg
    // one polling cycle; release and repeat strobes last only for the sampled cycle
    task automatic poll(input logic [7:0] t, r, h, k, n, input logic [63:0] dl);
        @(posedge mclk);
        poll_strobe <= 1'b1;
        front <= '{touch: t, release_ev: r, held: h, repeat_tick: k, noise: n};
        delta <= dl;
        @(posedge mclk);
        poll_strobe <= 1'b0;
        front.release_ev <= 8'h00;
        front.repeat_tick <= 8'h00;
        @(posedge mclk);
        #1;
    endtask : poll
    task automatic ci(input logic e);
        check("irq_n", {7'h0, irq_n}, {7'h0, e});
    endtask : ci
    task automatic ts(input logic [7:0] e);
        check("touch_status", touch_status, e);
    endtask : ts
    task automatic clr;
        host.wr(ADDR_STATUS, 8'h00);
        @(posedge mclk);
    endtask : clr
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        // reset values, unmapped address reads zero
        for (int i = 0; i < 6; i++) rreg(ra[i], 8'hFF, rv[i]);
        ci(1'b1);
        host.wr(ADDR_MT_CFG, 8'hFF);
        rreg(ADDR_MT_CFG, 8'hFF, 8'h8C);
        host.wr(ADDR_MT_CFG, RST_MT_CFG);
        // plain touch on input 1, release not selected
        poll(8'h01, 0, 0, 0, 0, 0);
        ts(8'h01);
        ci(1'b0);
        rreg(ADDR_STATUS, 8'hFF, 8'h01);
        clr();
        ci(1'b1);
        poll(8'h00, 8'h01, 0, 0, 0, 0);
        ci(1'b1);
        // enable cleared: status only
        host.wr(ADDR_IRQ_EN, 8'hFE);
        poll(8'h01, 0, 0, 0, 0, 0);
        ts(8'h01);
        ci(1'b1);
        poll(8'h00, 8'h01, 0, 0, 0, 0);
        host.wr(ADDR_IRQ_EN, 8'hFF);
        // hold with repeat on, then off
        release_irq_select <= 1'b1;
        poll(8'h01, 0, 8'h01, 0, 0, 0);
        ci(1'b0);
        clr();
        poll(8'h01, 0, 8'h01, 8'h01, 0, 0);
        ci(1'b0);
        clr();
        host.wr(ADDR_RPT_EN, 8'hFE);
        poll(8'h01, 0, 8'h01, 8'h01, 0, 0);
        ci(1'b1);
        poll(8'h00, 8'h01, 0, 0, 0, 0);
        ci(1'b0);
        clr();
        host.wr(ADDR_RPT_EN, 8'hFF);
        poll(8'h02, 0, 0, 0, 0, 0);
        ci(1'b0);
        clr();
        poll(8'h00, 8'h02, 0, 0, 0, 0);
        ci(1'b0);
        clr();
        // blocking at limit one, refill from input 1 upward, then limit four and blocking off
        poll(8'h05, 0, 0, 0, 0, 0);
        ts(8'h01);
        rreg(ADDR_TOUCH, 8'hFF, 8'h05);
        rreg(ADDR_STATUS, 8'hFF, 8'h03);
        poll(8'h04, 8'h01, 0, 0, 0, 0);
        ts(8'h04);
        poll(8'h00, 8'h04, 0, 0, 0, 0);
        clr();
        host.wr(ADDR_MT_CFG, 8'h8C);
        poll(8'h1F, 0, 0, 0, 0, 0);
        ts(8'h0F);
        poll(8'h00, 8'h1F, 0, 0, 0, 0);
        host.wr(ADDR_MT_CFG, 8'h00);
        clr();
        poll(8'hFF, 0, 0, 0, 0, 0);
        ts(8'hFF);
        rreg(ADDR_STATUS, 8'h02, 8'h00);
        poll(8'h00, 8'hFF, 0, 0, 0, 0);
        host.wr(ADDR_MT_CFG, RST_MT_CFG);
        clr();
        // pattern disabled: deltas do nothing
        poll(8'h01, 0, 0, 0, 8'hFF, {8{8'hFF}});
        ts(8'h01);
        // compare mode at full threshold, alert on
        host.wr(ADDR_PTRN, 8'h03);
        host.wr(ADDR_PTRN_CFG, 8'h8F);
        poll(8'h03, 0, 0, 0, 0, 64'h5050);
        ts(8'h00);
        check("alert_n", {7'h0, alert_n}, 8'h00);
        rreg(ADDR_STATUS, 8'h04, 8'h04);
        poll(8'h03, 0, 0, 0, 0, 64'h0050);
        ts(8'h01);
        rreg(ADDR_STATUS, 8'h04, 8'h04);
        clr();
        rreg(ADDR_STATUS, 8'h04, 8'h00);
        // count mode through noise flags, alert off
        host.wr(ADDR_PTRN_CFG, 8'h8C);
        poll(8'h03, 0, 0, 0, 8'h30, 0);
        ts(8'h00);
        check("alert_n", {7'h0, alert_n}, 8'h01);
        poll(8'h03, 0, 0, 0, 8'h10, 0);
        ts(8'h01);
        // 12.5 percent of 40h is 8: 8 passes, 9 blocks
        host.wr(ADDR_PTRN_CFG, 8'h82);
        host.wr(ADDR_PTRN, 8'h01);
        poll(8'h01, 0, 0, 0, 0, 64'h08);
        ts(8'h01);
        poll(8'h01, 0, 0, 0, 0, 64'h09);
        ts(8'h00);
        // 25 percent of 40h is 10h, 37.5 percent is 18h; in standby 37.5 percent of 80h is 30h
        host.wr(ADDR_PTRN_CFG, 8'h86);
        poll(8'h01, 0, 0, 0, 0, 64'h10);
        ts(8'h01);
        poll(8'h01, 0, 0, 0, 0, 64'h11);
        ts(8'h00);
        host.wr(ADDR_PTRN_CFG, 8'h8A);
        poll(8'h01, 0, 0, 0, 0, 64'h18);
        ts(8'h01);
        poll(8'h01, 0, 0, 0, 0, 64'h19);
        ts(8'h00);
        @(posedge mclk);
        standby <= 1'b1;
        poll(8'h01, 0, 0, 0, 0, 64'h19);
        ts(8'h01);
        poll(8'h01, 0, 0, 0, 0, 64'h31);
        ts(8'h00);
        // writes are ignored while the clock enable is low
        @(posedge mclk);
        clk_en <= 1'b0;
        host.wr(ADDR_PTRN, 8'h00);
        clk_en <= 1'b1;
        rreg(ADDR_PTRN, 8'hFF, 8'h01);
        stop_test();
    end
endmodule : touch_irq_and_multitouch_gate_tb
